// file: design/tgc_pkg.sv
// Purpose: Shared constants and types for the timer gate control block.
// Assumes: APB with 32-bit data, one register per aligned word.
// Notes:   Offsets and reset values are used by the design and the bench.
package tgc_pkg;
  // Register byte addresses.
  localparam logic [7:0] TGC_GATE_CONTROL_ADDR  = 8'h00;  // Gate control register.
  localparam logic [7:0] TGC_TIMER_CONTROL_ADDR = 8'h04;  // Timer control register.
  localparam logic [7:0] TGC_COUNT_LOW_ADDR     = 8'h08;  // Count low byte.
  localparam logic [7:0] TGC_COUNT_HIGH_ADDR    = 8'h0C;  // Count high byte.
  // Gate control field positions.
  localparam int TGC_BIT_GATE_ENABLE = 7;  // Gate enable.
  localparam int TGC_BIT_POLARITY    = 6;  // Gate polarity.
  localparam int TGC_BIT_TOGGLE      = 5;  // Toggle mode.
  localparam int TGC_BIT_SPM         = 4;  // Single-pulse mode.
  localparam int TGC_BIT_ARM         = 3;  // Single-pulse arm status.
  localparam int TGC_BIT_STATE       = 2;  // Gate current state.
  // Timer control field position.
  localparam int TGC_BIT_TIMER_ON    = 0;  // Timer on.
  // Reset values.
  localparam logic [7:0]  TGC_GATE_CONTROL_RST  = 8'h00;  // Gate control after reset.
  localparam logic [7:0]  TGC_TIMER_CONTROL_RST = 8'h00;  // Timer control after reset.
  localparam logic [15:0] TGC_COUNT_RST         = 16'h0000;  // Counter after reset.
  // Gate source encodings.
  typedef enum logic [1:0] {
    TGC_SRC_PIN  = 2'h0,  // Dedicated gate pin.
    TGC_SRC_TOVF = 2'h1,  // Other timer overflow.
    TGC_SRC_CMP1 = 2'h2,  // Comparator one output.
    TGC_SRC_CMP2 = 2'h3   // Comparator two output.
  } tgc_src_t;
  // Single-pulse acquisition states; each step changes one bit except open back to idle.
  typedef enum logic [1:0] {
    TGC_SP_IDLE = 2'h0,  // Not started or done.
    TGC_SP_WAIT = 2'h1,  // Armed, waiting for the opening edge.
    TGC_SP_OPEN = 2'h3   // Gate open, waiting for the closing edge.
  } tgc_sp_t;
  // Gate source inputs grouped together.
  typedef struct packed {
    logic pin;   // Gate pin level.
    logic tovf;  // Other timer overflow level.
    logic cmp1;  // Comparator one synchronized output.
    logic cmp2;  // Comparator two synchronized output.
  } tgc_gate_src_t;
endpackage : tgc_pkg

// file: design/tgc_top.sv
// Purpose: Gate control for a 16-bit timer, with APB register access.
// Assumes: Gate sources are synchronous to pclk; APB slave answers without waits.
// Notes:   The counter counts one per pclk while enabled by the gate.
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Contract
// - Polarity selects counting on high or low gate.
// - Toggle mode uses flip-flop; otherwise cleared, bypassed.
// - Arm bit: write one arms, reads one while busy.
// - Read-only bit shows live processed gate.
// - Two-bit field selects pin, overflow, comparators.
module tgc_top
  import tgc_pkg::*;
(
  input  wire logic          pclk,         // Clock, 250 MHz.
  input  wire logic          presetn,      // Asynchronous reset, active low.
  input  wire logic          psel,         // APB select.
  input  wire logic          penable,      // APB enable.
  input  wire logic          pwrite,       // APB direction.
  input  wire logic [7:0]    paddr,        // APB address.
  input  wire logic [31:0]   pwdata,       // APB write data.
  output logic      [31:0]   prdata,       // APB read data.
  output logic               pready,       // APB ready.
  output logic               pslverr,      // APB error on unmapped address.
  input  wire tgc_gate_src_t gate_src,     // Gate source levels.
  output logic               count_enable, // Gated count enable.
  output logic      [15:0]   count         // Counter value.
);

  //////////////////////////////////////////////////////////////////////////////
  // Register state.
  logic [7:0]  gcon_q;      // Writable gate control bits 7..4 and 1..0.
  logic        timer_on_q;  // Timer on bit.
  logic [15:0] count_q;     // The 16-bit counter.
  tgc_sp_t     sp_q;        // Single-pulse state.
  logic        tog_q;       // Toggle flip-flop.
  logic        gsel_q;      // Previous selected-and-polarised gate level.
  logic        ce_q;        // Registered count enable.

  // Decoded APB access strobes, valid in the access phase.
  logic acc;  // Access phase.
  logic wr;   // Write in access phase.
  assign acc = psel & penable;
  assign wr  = acc & pwrite;

  // Returns true when the address is a mapped register.
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == TGC_GATE_CONTROL_ADDR) || (a == TGC_TIMER_CONTROL_ADDR) ||
             (a == TGC_COUNT_LOW_ADDR) || (a == TGC_COUNT_HIGH_ADDR);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Gate path, combinational.
  logic gate_raw;   // Selected source.
  logic gate_pol;   // After polarity.
  logic rise;       // Rising edge of polarised gate.
  logic gate_proc;  // Processed gate as applied to the counter.
  logic sp_arm_w;   // Software arms the single pulse this cycle.
  always_comb begin
    // Pick the source by the select field.
    case (tgc_src_t'(gcon_q[1:0]))
      TGC_SRC_PIN:  gate_raw = gate_src.pin;
      TGC_SRC_TOVF: gate_raw = gate_src.tovf;
      TGC_SRC_CMP1: gate_raw = gate_src.cmp1;
      TGC_SRC_CMP2: gate_raw = gate_src.cmp2;
      default:      gate_raw = gate_src.pin;
    endcase
    // Low polarity inverts so that counting happens while the gate is low.
    gate_pol = gcon_q[TGC_BIT_POLARITY] ? gate_raw : ~gate_raw;
    // A rising edge is the polarised gate high now and low one cycle earlier.
    rise     = gate_pol & ~gsel_q;
    // Toggle mode opens the gate for one whole source period.
    if (gcon_q[TGC_BIT_SPM]) begin
      gate_proc = (sp_q == TGC_SP_OPEN);
    end else if (gcon_q[TGC_BIT_TOGGLE]) begin
      gate_proc = tog_q;
    end else begin
      gate_proc = gate_pol;
    end
  end
  // Arming is only accepted while single-pulse mode is already switched on.
  assign sp_arm_w = wr && (paddr == TGC_GATE_CONTROL_ADDR) && pwdata[TGC_BIT_ARM]
                    && gcon_q[TGC_BIT_SPM];

  //////////////////////////////////////////////////////////////////////////////
  // Edge history of the polarised gate.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Reset to the polarised idle level: low polarity and a low gate read high.
      // Starting from the same level keeps a false edge from following reset.
      gsel_q <= 1'b1;
    end else begin
      gsel_q <= gate_pol;
    end
  end

  // Toggle flip-flop flips on each rising edge, held clear when mode is off.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tog_q <= 1'b0;
    end else if (!gcon_q[TGC_BIT_TOGGLE]) begin
      tog_q <= 1'b0;
    end else if (rise) begin
      tog_q <= ~tog_q;
    end
  end

  // Single pulse: armed waits for an edge, then opens until the closing edge.
  // With toggle mode the closing edge is the next rising edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp_q <= TGC_SP_IDLE;
    end else if (!gcon_q[TGC_BIT_SPM]) begin
      sp_q <= TGC_SP_IDLE;
    end else begin
      case (sp_q)
        TGC_SP_IDLE: begin
          if (sp_arm_w) begin
            sp_q <= TGC_SP_WAIT;
          end
        end
        TGC_SP_WAIT: begin
          if (rise) begin
            sp_q <= TGC_SP_OPEN;
          end
        end
        TGC_SP_OPEN: begin
          if (gcon_q[TGC_BIT_TOGGLE] ? rise : ~gate_pol) begin
            sp_q <= TGC_SP_IDLE;
          end
        end
        default: sp_q <= TGC_SP_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register writes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gcon_q     <= TGC_GATE_CONTROL_RST;
      timer_on_q <= TGC_TIMER_CONTROL_RST[TGC_BIT_TIMER_ON];
    end else if (wr) begin
      if (paddr == TGC_GATE_CONTROL_ADDR) begin
        // Arm status lives in the pulse machine and the state bit is read-only,
        // so bits 3 and 2 of this copy stay zero.
        gcon_q <= {pwdata[7:4], 2'h0, pwdata[1:0]};
      end
      if (paddr == TGC_TIMER_CONTROL_ADDR) begin
        timer_on_q <= pwdata[TGC_BIT_TIMER_ON];
      end
    end
  end

  // Count enable and the counter; software writes take priority.
  logic ce_d;  // Next count enable.
  assign ce_d = timer_on_q & (gcon_q[TGC_BIT_GATE_ENABLE] ? gate_proc : 1'b1);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= TGC_COUNT_RST;
      ce_q    <= 1'b0;
    end else begin
      ce_q  <= ce_d;
      // A write to either byte wins over an increment in the same cycle.
      if (wr && paddr == TGC_COUNT_LOW_ADDR) begin
        count_q[7:0] <= pwdata[7:0];
      end else if (wr && paddr == TGC_COUNT_HIGH_ADDR) begin
        count_q[15:8] <= pwdata[7:0];
      end else if (ce_d) begin
        count_q <= count_q + 16'h0001;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // APB read data, ready and error, all registered.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      // Ready rises in the access cycle that follows every setup cycle; error rises there only for an unmapped address.
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped(paddr);
      prdata  <= 32'h0000_0000;
      // Read data is captured in the setup cycle and shown in the access cycle.
      if (psel && !penable && !pwrite) begin
        case (paddr)
          TGC_GATE_CONTROL_ADDR: prdata <= {24'h00_0000, gcon_q[7:4],
                                            (sp_q != TGC_SP_IDLE), gate_proc,
                                            gcon_q[1:0]};
          TGC_TIMER_CONTROL_ADDR: prdata <= {31'h0000_0000, timer_on_q};
          TGC_COUNT_LOW_ADDR:     prdata <= {24'h00_0000, count_q[7:0]};
          TGC_COUNT_HIGH_ADDR:    prdata <= {24'h00_0000, count_q[15:8]};
          default:                prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Both outputs come straight from their flip-flops.
  assign count_enable = ce_q;
  assign count        = count_q;

  //////////////////////////////////////////////////////////////////////////////
  // Checks.
  // These properties watch the gate path, the single-pulse machine and the
  // read path. Each comment above a check states the rule that it guards. Internal
  // nets are used where the pins alone cannot show the cause of a failure.

  // With the gate enabled and both special modes off, the count enable must
  // follow the selected source after the polarity choice, one cycle later.
  AST_POLARITY_PASS: assert property (@(posedge pclk) disable iff (!presetn)
    (timer_on_q && gcon_q[7] && !gcon_q[5] && !gcon_q[4]) |=>
      (count_enable == $past(gcon_q[6] ? gate_raw : ~gate_raw)))
    else $error("Polarity not applied to count enable.");

  // Leaving toggle mode must clear the toggle flip-flop at the next edge.
  AST_TOGGLE_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    !gcon_q[5] |=> !tog_q)
    else $error("Toggle flip-flop not held clear.");

  // In toggle mode every rising edge of the polarised gate flips the flop.
  AST_TOGGLE_FLIP: assert property (@(posedge pclk) disable iff (!presetn)
    (gcon_q[5] && rise) |=> (tog_q != $past(tog_q)))
    else $error("Toggle flip-flop missed an edge.");

  // A one written to the arm bit while idle must start the wait for an edge.
  AST_ARM_SETS: assert property (@(posedge pclk) disable iff (!presetn)
    (sp_arm_w && sp_q == TGC_SP_IDLE) |=> (sp_q == TGC_SP_WAIT))
    else $error("Arm write did not arm.");

  // While armed, only a rising edge may move the machine on.
  AST_WAIT_HOLDS: assert property (@(posedge pclk) disable iff (!presetn)
    (sp_q == TGC_SP_WAIT && gcon_q[4] && !rise) |=> (sp_q == TGC_SP_WAIT))
    else $error("Armed state left without an edge.");

  // The first rising edge after arming must open the gate.
  AST_PULSE_OPENS: assert property (@(posedge pclk) disable iff (!presetn)
    (sp_q == TGC_SP_WAIT && gcon_q[4] && rise) |=> (sp_q == TGC_SP_OPEN))
    else $error("Armed pulse did not open on the edge.");

  // Without toggle mode the falling edge of the gate ends the single pulse.
  AST_PULSE_CLOSES: assert property (@(posedge pclk) disable iff (!presetn)
    (sp_q == TGC_SP_OPEN && gcon_q[4] && !gcon_q[5] && !gate_pol) |=>
      (sp_q == TGC_SP_IDLE))
    else $error("Single pulse did not close on the falling edge.");

  // With toggle mode the pulse lasts until the next rising edge instead.
  AST_TOGGLE_PULSE_END: assert property (@(posedge pclk) disable iff (!presetn)
    (sp_q == TGC_SP_OPEN && gcon_q[4] && gcon_q[5] && rise) |=>
      (sp_q == TGC_SP_IDLE))
    else $error("Toggled single pulse did not close.");

  // Clearing single-pulse mode abandons any acquisition in progress.
  AST_SPM_OFF_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
    !gcon_q[4] |=> (sp_q == TGC_SP_IDLE))
    else $error("Pulse machine busy with the mode off.");

  // A read of gate control returns the arm status as it stood at setup.
  AST_STATUS_READ: assert property (@(posedge pclk) disable iff (!presetn)
    (acc && !pwrite && paddr == TGC_GATE_CONTROL_ADDR) |->
      (prdata[TGC_BIT_ARM] == $past(sp_q != TGC_SP_IDLE)))
    else $error("Arm status read wrong.");

  // A read of gate control returns the processed gate as it stood at setup.
  AST_STATE_BIT: assert property (@(posedge pclk) disable iff (!presetn)
    (acc && !pwrite && paddr == TGC_GATE_CONTROL_ADDR) |->
      (prdata[TGC_BIT_STATE] == $past(gate_proc)))
    else $error("Gate state bit wrong.");

  // Each encoding of the source field picks its own input, so a swapped
  // pair of sources shows up here before it shows up in the count.
  AST_SOURCE_PIN: assert property (@(posedge pclk) disable iff (!presetn)
    (gcon_q[1:0] == 2'h0) |-> (gate_raw == gate_src.pin))
    else $error("Pin source select wrong.");
  AST_SOURCE_OVF: assert property (@(posedge pclk) disable iff (!presetn)
    (gcon_q[1:0] == 2'h1) |-> (gate_raw == gate_src.tovf))
    else $error("Overflow source select wrong.");
  AST_SOURCE_CMP1: assert property (@(posedge pclk) disable iff (!presetn)
    (gcon_q[1:0] == 2'h2) |-> (gate_raw == gate_src.cmp1))
    else $error("Comparator one source select wrong.");
  AST_SOURCE_CMP2: assert property (@(posedge pclk) disable iff (!presetn)
    (gcon_q[1:0] == 2'h3) |-> (gate_raw == gate_src.cmp2))
    else $error("Comparator two source select wrong.");

  // With the timer on and the gate enabled, counting follows the processed
  // gate, whichever of the plain, toggle or single-pulse paths produced it.
  AST_GATED_COUNT: assert property (@(posedge pclk) disable iff (!presetn)
    (timer_on_q && gcon_q[7]) |=> (count_enable == $past(gate_proc)))
    else $error("Count enable does not follow the gate.");

  // With the gate function off the timer counts on every cycle.
  AST_FREE_RUN: assert property (@(posedge pclk) disable iff (!presetn)
    (timer_on_q && !gcon_q[7]) |=> count_enable)
    else $error("Timer did not run free.");

  // A switched-off timer never counts, whatever the gate does.
  AST_OFF_STOPS: assert property (@(posedge pclk) disable iff (!presetn)
    !timer_on_q |=> !count_enable)
    else $error("Timer counted while off.");

endmodule : tgc_top // tgc_top

// file: dv/tgc_gate_model.sv
// Purpose: Far-side model of the gate sources (pin, overflow, comparators).
// Assumes: Levels change just after a rising pclk edge, as real sync outputs do.
// Notes:   The bench asks for levels; the model launches them on the next edge.
`timescale 1ns/1ps
module tgc_gate_model
  import tgc_pkg::*;
(
  input  wire logic       pclk,     // Timer clock.
  input  wire logic       presetn,  // Reset, active low.
  input  wire logic [3:0] lvl_req,  // Requested levels {pin,tovf,cmp1,cmp2}.
  output tgc_gate_src_t   gate_src  // Source levels seen by the block.
);
  // Register the requested levels so they move only after a clock edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_src <= '0;
    end else begin
      gate_src <= tgc_gate_src_t'(lvl_req);
    end
  end
endmodule // tgc_gate_model

// file: dv/testbench.sv
// Purpose: Self-checking bench for the timer gate control block.
// Assumes: Zero-wait APB slave; gate sources synchronous to pclk.
// Notes:   Random levels use a fixed seed so the run repeats.
`timescale 1ns/1ps
`define CHK(a, b, m) begin checks++; if ((a) !== (b)) begin bad_count++; \
  $display("unexpected at %0t: %s", $time, m); end end
module testbench;
  import tgc_pkg::*;
  logic          pclk, presetn, psel, penable, pwrite, pready, pslverr, count_enable, err, p;
  logic [7:0]    paddr, g0;
  logic [31:0]   pwdata, prdata, rd;
  logic [15:0]   count, c0;
  logic [3:0]    lvl;
  logic [1:0]    s;
  tgc_gate_src_t gate_src;
  int            bad_count, checks, cyc, seed;
  tgc_top u_tgc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .gate_src(gate_src), .count_enable(count_enable), .count(count));
  tgc_gate_model u_tgc_gate_model (.pclk(pclk), .presetn(presetn), .lvl_req(lvl),
    .gate_src(gate_src));
  ////////////////////////////////////////////////////////////////////////////
  // Expected processed gate for a level set, source and polarity.
  function automatic logic gexp(logic [3:0] l, logic [1:0] sel, logic pol);
    return pol ? l[3-sel] : ~l[3-sel];
  endfunction
  // One APB transfer; read data and error are taken at the pready edge.
  // The access phase lasts until pready; only the cycle ceiling ends a hang.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk); psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk); penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata; err = pslverr; psel <= 0; penable <= 0;
  endtask
  task automatic tick(input int n); repeat (n) @(posedge pclk); endtask
  task automatic pulse(); lvl <= 4'h8; tick(2); lvl <= 4'h0; tick(3); endtask
  task automatic final_report();
    if (bad_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard.
  initial begin pclk = 0; forever #2 pclk = ~pclk; end
  always @(posedge pclk) begin cyc++; if (cyc > 20000) begin bad_count++; final_report(); end end
  initial begin
    seed = 67; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    lvl = 0; bad_count = 0; checks = 0; cyc = 0;
    repeat (2) @(posedge pclk); presetn <= 1;
    // After reset the polarity is low, so a low pin reads as an open gate.
    apb(0, TGC_GATE_CONTROL_ADDR, 0); g0 = TGC_GATE_CONTROL_RST;
    `CHK(rd, {24'h0, g0[7:3], gexp(lvl, g0[1:0], g0[TGC_BIT_POLARITY]), g0[1:0]}, "rst")
    apb(0, 8'h10, 0); `CHK({err, rd}, 33'h1_0000_0000, "unmapped")
    // Free counting with the gate function off.
    apb(1, TGC_TIMER_CONTROL_ADDR, 32'h1); apb(1, TGC_GATE_CONTROL_ADDR, 0); tick(2);
    c0 = count; tick(10); `CHK(count, c0 + 16'h000A, "free count")
    // Every source and polarity against random levels.
    for (int i = 0; i < 24; i++) begin
      s = i[1:0]; p = i[2]; lvl <= 4'($random(seed));
      apb(1, TGC_GATE_CONTROL_ADDR, {24'h0, 1'b1, p, 4'h0, s}); tick(3);
      `CHK(count_enable, gexp(lvl, s, p), "gated enable")
      apb(0, TGC_GATE_CONTROL_ADDR, 0);
      `CHK(rd, {24'h0, 1'b1, p, 3'h0, gexp(lvl, s, p), s}, "gate state")
    end
    lvl <= 0; apb(1, TGC_GATE_CONTROL_ADDR, 32'hC0); tick(2);
    c0 = count; tick(6); `CHK(count, c0, "closed gate holds")
    // Toggle mode: each rising edge flips the gate; leaving it clears the flop.
    apb(1, TGC_GATE_CONTROL_ADDR, 32'hE0); tick(3); `CHK(count_enable, 1'b0, "tgl idle")
    pulse(); `CHK(count_enable, 1'b1, "tgl open")
    pulse(); `CHK(count_enable, 1'b0, "tgl close")
    pulse(); apb(1, TGC_GATE_CONTROL_ADDR, 32'hC0); apb(1, TGC_GATE_CONTROL_ADDR, 32'hE0);
    tick(3); `CHK(count_enable, 1'b0, "tgl cleared")
    // Single pulse: arm, open, close, then stay shut.
    apb(1, TGC_GATE_CONTROL_ADDR, 32'hD0); apb(1, TGC_GATE_CONTROL_ADDR, 32'hD8);
    apb(0, TGC_GATE_CONTROL_ADDR, 0); `CHK(rd[3], 1'b1, "armed")
    // The pulse state moves one edge after the gate edge and shows one edge later.
    lvl <= 4'h8; tick(4); `CHK(count_enable, 1'b1, "sp open")
    apb(0, TGC_GATE_CONTROL_ADDR, 0); `CHK(rd[3], 1'b1, "sp busy")
    lvl <= 4'h0; tick(4); `CHK(count_enable, 1'b0, "sp close")
    apb(0, TGC_GATE_CONTROL_ADDR, 0); `CHK(rd[3], 1'b0, "sp done")
    pulse(); `CHK(count_enable, 1'b0, "sp once")
    // Single pulse in toggle mode: open on one rising edge, close on the next.
    apb(1, TGC_GATE_CONTROL_ADDR, 32'hF0); apb(1, TGC_GATE_CONTROL_ADDR, 32'hF8);
    pulse(); `CHK(count_enable, 1'b1, "sp tgl open")
    pulse(); `CHK(count_enable, 1'b0, "sp tgl close")
    apb(0, TGC_GATE_CONTROL_ADDR, 0); `CHK(rd[3], 1'b0, "sp tgl done")
    // Timer off stops counting; count bytes load independently.
    apb(1, TGC_TIMER_CONTROL_ADDR, 0); apb(1, TGC_GATE_CONTROL_ADDR, 0); tick(3);
    `CHK(count_enable, 1'b0, "timer off")
    apb(1, TGC_COUNT_LOW_ADDR, 32'h34); apb(1, TGC_COUNT_HIGH_ADDR, 32'h12);
    apb(0, TGC_COUNT_HIGH_ADDR, 0); `CHK(rd, 32'h12, "high byte")
    `CHK(count, 16'h1234, "count load")
    final_report();
  end
endmodule // testbench
